// ==== field_contacts_model.sv ====
// field device contacts that feed the evaluator pins
`timescale 1ns/10ps
`default_nettype none
module field_contacts_model
(
  input  wire logic [7:0] act_in,    // contact actuated per pin
  input  wire logic [7:0] nc_in,     // contact is normally closed
  input  wire logic       btn_in,    // push button pressed
  input  wire logic       share_in,  // pin 0 shared with a lit button
  input  wire logic       drive_in,  // evaluator drive level on pin 0
  input  wire logic       oe_in,     // evaluator drives pin 0
  output logic      [7:0] pin_out    // resolved line levels
);
  // ----------------------------------------------------------------
  // contact levels
  // ----------------------------------------------------------------
  // a closed contact pulls its line high; an open one reads low
  always_comb
  begin
    pin_out = act_in ^ nc_in;
    // shared pin: evaluator drive wins over the button
    if (share_in)
      pin_out[0] = oe_in ? drive_in : btn_in;
  end
endmodule
`default_nettype wire

// ==== safety_input_cfg.svh ====
// constants for the safety input evaluator
`ifndef SAFETY_INPUT_CFG_SVH
`define SAFETY_INPUT_CFG_SVH
// timing in ns, clock at 100 MHz
`define CLK_PERIOD_NS 10
`define MS_TIME_NS 1000000
`define PB_OUT_TIME_NS 1500000
`define PB_IN_TIME_NS 500000
// register byte addresses
`define OFS_CTRL 5'h00
`define OFS_FILTER 5'h04
`define OFS_SIMUL 5'h08
`define OFS_DWELL 5'h0C
`define OFS_PATTERN 5'h10
`define OFS_STATE 5'h14
`define OFS_IRQ_STAT 5'h18
`define OFS_IRQ_MASK 5'h1C
// control field positions
`define CTRL_VAR_LSB 0
`define CTRL_SUB_LSB 3
`define CTRL_CNT_LSB 5
`define CTRL_OBO_BIT 9
`define CTRL_DWELL_BIT 10
`define CTRL_LAMP_BIT 11
// reset values
`define CTRL_RESET 12'h220
`define FILTER_RESET 16'h000A
`define SIMUL_RESET 16'h0064
`define DWELL_RESET 16'h0064
`define PATTERN_RESET 16'h00FF
// irq status bits
`define IRQ_ON_BIT 0
`define IRQ_OFF_BIT 1
`define IRQ_ERR_BIT 2
`define IRQ_SIMUL_BIT 3
`endif

// ==== safety_input_evaluator.sv ====
// safety input evaluator with avalon-mm register slave
// ----------------------------------------------------------------
// Overview of operation
// - on output high only in ON state, low in OFF or ERROR.
// - error output high only in ERROR state.
// - a pin counts ON only after staying ON longer than filter time.
// - with start-up check, a valid OFF must be seen before ON.
// - ON only if all pins reach ON within the simultaneity time.
// - after simultaneity failure, all pins must go OFF before retrying.
// - with dwell enabled, all pins stay OFF for dwell time first.
// - custom evaluator uses one to eight pins.
// - each pin has its own ON and OFF pattern bit.
// - selector uses single NO, double NO or NC/NO contacts.
// - door sensor is ON only when both pins show ON.
// - emergency stop uses single NC, double NC or NC/NO contacts.
// - push button pin drives 1.5 ms then senses 0.5 ms, repeating.
// - lamp input drives the button lamp during the drive phase.
// - push button ON only after sensed high longer than filter.
// ----------------------------------------------------------------
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`include "safety_input_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module safety_input_evaluator
  import safety_input_pkg::*;
#(
  parameter int MS_CYCLES  = `MS_TIME_NS / `CLK_PERIOD_NS,
  parameter int PB_OUT_CYC = `PB_OUT_TIME_NS / `CLK_PERIOD_NS,
  parameter int PB_IN_CYC  = `PB_IN_TIME_NS / `CLK_PERIOD_NS,
  parameter int PINS       = 8
)
(
  input  wire logic        clk_in,         // system clock
  input  wire logic        rst_b_in,       // sync reset, active low
  input  wire logic        ce_in,          // clock enable
  input  wire logic [4:0]  address_in,     // avalon byte address
  input  wire logic        read_in,        // avalon read
  input  wire logic        write_in,       // avalon write
  input  wire logic [31:0] writedata_in,   // avalon write data
  output var  logic [31:0] readdata_out,   // avalon read data
  output logic             waitrequest_out,// avalon wait
  input  wire logic [7:0]  pin_in,         // field pin levels
  input  wire logic        lamp_in,        // button lamp request
  output var  logic        pb_drive_out,   // button pin drive level
  output var  logic        pb_oe_out,      // button pin output enable
  output logic             on_out,         // function in ON state
  output logic             error_out,      // function in ERROR state
  output logic             irq_out         // level interrupt
);
  localparam int CW = 20;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
  endfunction
  // variant decode: {count-1, on pattern, off pattern}
  function automatic logic [18:0] var_cfg(input variant_type v, input logic [1:0] sub,
                                          input logic [3:0] cnt, input logic [15:0] pat);
    // register pattern: low byte is the on level, high byte the off level
    var_cfg = {3'h0, pat[7:0], pat[15:8]};
    unique case (v)
      VAR_ADVANCED: var_cfg = {cnt[2:0], pat[7:0], pat[15:8]};
      VAR_SELECTOR: var_cfg = (sub == 2'h0) ? {3'h0, 8'h01, 8'h00} :
                              (sub == 2'h1) ? {3'h1, 8'h03, 8'h00} : {3'h1, 8'h02, 8'h01};
      VAR_ESTOP:    var_cfg = (sub == 2'h0) ? {3'h0, 8'h01, 8'h00} :
                              (sub == 2'h1) ? {3'h1, 8'h03, 8'h00} : {3'h1, 8'h01, 8'h02};
      VAR_DOOR,
      VAR_LIGHT:    var_cfg = {3'h1, pat[7:0], pat[15:8]};
      VAR_BUTTON:   var_cfg = {3'h0, 8'h01, 8'h00};
      default:      var_cfg = {cnt[2:0], pat[7:0], pat[15:8]};
    endcase
  endfunction

  // ----------------------------------------------------------------
  // register slave
  // ----------------------------------------------------------------
  logic [11:0] ctrl_reg;
  logic [15:0] filter_reg, simul_reg, dwell_reg, pattern_reg;
  logic [3:0]  irq_stat_reg, irq_mask_reg, irq_set;
  logic        ack_reg;
  eval_state_type state_reg, state_next;
  logic [7:0]  filt_on;
  wire logic   req = read_in | write_in;
  wire logic   wr_go = ce_in & write_in & ack_reg;
  // one wait cycle, then the access completes
  assign waitrequest_out = req & ~ack_reg;
  always_ff @(posedge clk_in)
    if (!rst_b_in) ack_reg <= 1'b0;
    else if (ce_in) ack_reg <= req & ~ack_reg;
  // read data latched in the wait cycle, stands at completion
  always_ff @(posedge clk_in)
    if (!rst_b_in) readdata_out <= 32'h0000_0000;
    else if (ce_in && read_in && !ack_reg)
      unique case (address_in)
        `OFS_CTRL:     readdata_out <= {20'h0, ctrl_reg};
        `OFS_FILTER:   readdata_out <= {16'h0, filter_reg};
        `OFS_SIMUL:    readdata_out <= {16'h0, simul_reg};
        `OFS_DWELL:    readdata_out <= {16'h0, dwell_reg};
        `OFS_PATTERN:  readdata_out <= {16'h0, pattern_reg};
        `OFS_STATE:    readdata_out <= {8'h0, pin_in, filt_on, 5'h0, state_reg};
        `OFS_IRQ_STAT: readdata_out <= {28'h0, irq_stat_reg};
        `OFS_IRQ_MASK: readdata_out <= {28'h0, irq_mask_reg};
        default:       readdata_out <= 32'h0000_0000;
      endcase
  // configuration writes
  always_ff @(posedge clk_in)
    if (!rst_b_in)
    begin
      ctrl_reg     <= `CTRL_RESET;
      filter_reg   <= `FILTER_RESET;
      simul_reg    <= `SIMUL_RESET;
      dwell_reg    <= `DWELL_RESET;
      pattern_reg  <= `PATTERN_RESET;
      irq_mask_reg <= 4'h0;
    end
    else if (wr_go)
      unique case (address_in)
        `OFS_CTRL:     ctrl_reg     <= writedata_in[11:0];
        `OFS_FILTER:   filter_reg   <= writedata_in[15:0];
        `OFS_SIMUL:    simul_reg    <= writedata_in[15:0];
        `OFS_DWELL:    dwell_reg    <= writedata_in[15:0];
        `OFS_PATTERN:  pattern_reg  <= writedata_in[15:0];
        `OFS_IRQ_MASK: irq_mask_reg <= writedata_in[3:0];
        default:       ;
      endcase
  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge clk_in)
    if (!rst_b_in) irq_stat_reg <= 4'h0;
    else if (ce_in)
      irq_stat_reg <= (irq_stat_reg & ~((wr_go && address_in == `OFS_IRQ_STAT) ?
                       writedata_in[3:0] : 4'h0)) | irq_set;
  assign irq_out = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // configuration decode
  // ----------------------------------------------------------------
  variant_type var_sel;
  logic [18:0] vcfg;
  logic [7:0]  pin_mask, on_pat, off_pat, src, on_hit, off_hit;
  assign var_sel = variant_type'(ctrl_reg[`CTRL_VAR_LSB +: 3]);
  assign vcfg    = var_cfg(var_sel, ctrl_reg[`CTRL_SUB_LSB +: 2],
                           ctrl_reg[`CTRL_CNT_LSB +: 4], pattern_reg);
  assign on_pat  = vcfg[15:8];
  assign off_pat = vcfg[7:0];
  assign pin_mask = 8'hFF >> (3'h7 - vcfg[18:16]);

  // ----------------------------------------------------------------
  // timebase and push button time sharing
  // ----------------------------------------------------------------
  logic [CW-1:0] ms_cnt_reg, pb_cnt_reg;
  logic          ms_tick, pb_sample_reg;
  assign ms_tick = (ms_cnt_reg == CW'(MS_CYCLES - 1));
  always_ff @(posedge clk_in)
    if (!rst_b_in) ms_cnt_reg <= '0;
    else if (ce_in) ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 1'b1;
  // drive phase, then sense phase, repeating
  always_ff @(posedge clk_in)
    if (!rst_b_in)
    begin
      pb_cnt_reg <= '0;
      pb_oe_out  <= 1'b0;
    end
    else if (ce_in)
    begin
      if (var_sel != VAR_BUTTON)
      begin
        pb_cnt_reg <= '0;
        pb_oe_out  <= 1'b0;
      end
      else if (pb_cnt_reg == CW'((pb_oe_out ? PB_OUT_CYC : PB_IN_CYC) - 1))
      begin
        pb_cnt_reg <= '0;
        pb_oe_out  <= ~pb_oe_out;
      end
      else pb_cnt_reg <= pb_cnt_reg + 1'b1;
    end
  always_ff @(posedge clk_in)
    if (!rst_b_in) pb_drive_out <= 1'b0;
    else if (ce_in)
      pb_drive_out <= (var_sel == VAR_BUTTON) & lamp_in & ctrl_reg[`CTRL_LAMP_BIT];
  // sense at the end of the input phase, pin has settled by then
  always_ff @(posedge clk_in)
    if (!rst_b_in) pb_sample_reg <= 1'b0;
    else if (ce_in && var_sel == VAR_BUTTON && !pb_oe_out &&
             pb_cnt_reg == CW'(PB_IN_CYC - 1))
      pb_sample_reg <= pin_in[0];

  // ----------------------------------------------------------------
  // pin classification and on filter
  // ----------------------------------------------------------------
  logic [15:0] filt_cnt_reg [PINS];
  assign src = (var_sel == VAR_BUTTON) ? {7'h00, pb_sample_reg} : pin_in;
  // per pin on and off pattern
  assign on_hit  = pin_mask & ~(src ^ on_pat);
  assign off_hit = pin_mask & ~(src ^ off_pat);
  // rising edge filtered in ms, same for the button
  always_ff @(posedge clk_in)
    if (!rst_b_in)
      for (int i = 0; i < PINS; i++) filt_cnt_reg[i] <= 16'h0000;
    else if (ce_in)
      for (int i = 0; i < PINS; i++)
        if (!on_hit[i]) filt_cnt_reg[i] <= 16'h0000;
        else if (ms_tick && filt_cnt_reg[i] <= filter_reg)
          filt_cnt_reg[i] <= sat_inc(filt_cnt_reg[i]);
  always_comb
    for (int i = 0; i < 8; i++)
      filt_on[i] = (i < PINS) && on_hit[i] && (filt_cnt_reg[i] > filter_reg);

  logic all_on, any_on, all_off, invalid;
  assign all_on  = &(filt_on | ~pin_mask);
  assign any_on  = |filt_on;
  assign all_off = (off_hit == pin_mask);
  assign invalid = |(pin_mask & ~(on_hit | off_hit));

  // ----------------------------------------------------------------
  // simultaneity and dwell timers
  // ----------------------------------------------------------------
  logic [15:0] simul_cnt_reg, dwell_cnt_reg;
  logic        simul_fail, dwell_ok;
  always_ff @(posedge clk_in)
    if (!rst_b_in) simul_cnt_reg <= 16'h0000;
    else if (ce_in)
      if (state_reg != ST_ARM) simul_cnt_reg <= 16'h0000;
      else if (ms_tick) simul_cnt_reg <= sat_inc(simul_cnt_reg);
  assign simul_fail = (simul_cnt_reg > simul_reg);
  // all off for the dwell time
  always_ff @(posedge clk_in)
    if (!rst_b_in) dwell_cnt_reg <= 16'h0000;
    else if (ce_in)
      // a dwell met while ready is kept, else the on filter delay would lose it
      if (!all_off && !(state_reg == ST_READY && dwell_cnt_reg >= dwell_reg))
        dwell_cnt_reg <= 16'h0000;
      else if (ms_tick) dwell_cnt_reg <= sat_inc(dwell_cnt_reg);
  assign dwell_ok = !ctrl_reg[`CTRL_DWELL_BIT] || (dwell_cnt_reg >= dwell_reg);

  // ----------------------------------------------------------------
  // evaluation state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      // wait for a valid off state
      ST_WAIT:  if (invalid) state_next = ST_ERR;
                else if (all_off) state_next = ST_READY;
      ST_READY: if (invalid) state_next = ST_ERR;
                else if (any_on && dwell_ok) state_next = ST_ARM;
      // all on within the window, both door pins
      ST_ARM:   if (invalid || simul_fail) state_next = ST_ERR;
                else if (all_on) state_next = ST_ON;
                else if (all_off) state_next = ST_READY;
      ST_ON:    if (invalid) state_next = ST_ERR;
                else if (!all_on) state_next = ST_WAIT;
      // leave error only when all off
      ST_ERR:   if (all_off) state_next = ST_READY;
      default:  state_next = ST_ERR;
    endcase
  end
  // reset always enters the wait state, so a valid off is needed before on
  always_ff @(posedge clk_in)
    if (!rst_b_in) state_reg <= ST_WAIT;
    else if (ce_in) state_reg <= state_next;
  assign irq_set = ce_in ? {state_reg == ST_ARM && state_next == ST_ERR,
                            state_reg != ST_ERR && state_next == ST_ERR,
                            state_reg == ST_ON && state_next != ST_ON,
                            state_reg != ST_ON && state_next == ST_ON} : 4'h0;
  assign on_out    = (state_reg == ST_ON);
  assign error_out = (state_reg == ST_ERR);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence arm_seq;
    state_reg == ST_ARM;
  endsequence
  sequence on_seq;
    state_reg == ST_ON;
  endsequence
  on_entry_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(on_out) |-> $past(state_reg) == ST_ARM && !error_out)
    else $error("on output rose without arming");
  err_level_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    error_out |-> !on_out ##1 (error_out || $past(all_off)))
    else $error("error output left early");
  filter_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    filt_on[0] |-> filt_cnt_reg[0] > filter_reg && on_hit[0])
    else $error("pin counted on before filter time");
  startup_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(rst_b_in) |-> !on_out [*2])
    else $error("on directly after reset");
  simul_win_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    arm_seq ##1 on_seq |-> $past(simul_cnt_reg) <= simul_reg)
    else $error("on outside simultaneity window");
  retry_block_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && state_reg == ST_ARM && simul_fail |=> error_out)
    else $error("simultaneity failure not caught");
  dwell_gate_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(state_reg == ST_ARM) && $past(ctrl_reg[`CTRL_DWELL_BIT])
      |-> $past(dwell_cnt_reg) >= $past(dwell_reg))
    else $error("armed before dwell time");
  lamp_phase_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pb_oe_out && pb_drive_out |-> var_sel == VAR_BUTTON)
    else $error("lamp driven outside button mode");
  phase_len_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    pb_cnt_reg < CW'(PB_OUT_CYC))
    else $error("button phase too long");
  err_cause_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ce_in && invalid |=> error_out)
    else $error("invalid pattern not flagged");
endmodule
`default_nettype wire

// ==== safety_input_pkg.sv ====
// types for the safety input evaluator
package safety_input_pkg;
  typedef enum logic [2:0] {
    ST_WAIT  = 3'h0,
    ST_READY = 3'h1,
    ST_ARM   = 3'h3,
    ST_ON    = 3'h2,
    ST_ERR   = 3'h6
  } eval_state_type;
  typedef enum logic [2:0] {
    VAR_ADVANCED = 3'h0,
    VAR_SELECTOR = 3'h1,
    VAR_DOOR     = 3'h2,
    VAR_LIGHT    = 3'h3,
    VAR_ESTOP    = 3'h4,
    VAR_BUTTON   = 3'h5
  } variant_type;
endpackage

// ==== test_safety_input_evaluator.sv ====
// self-checking bench for the safety input evaluator
`include "safety_input_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module test_safety_input_evaluator import safety_input_pkg::*;;
  typedef struct packed {
    logic [11:0] ctrl;
    logic [7:0]  nc;
    logic [7:0]  off_act;
    logic [7:0]  on_act;
    logic        exp_on;
    logic        exp_err;
  } row_type;
  // twelve rows of contact variants, two of them failing: config, idle and actuated contacts, outcome
  localparam row_type ROWS [12] = '{
    '{12'h201, 8'h00, 8'h00, 8'h01, 1'b1, 1'b0}, '{12'h209, 8'h00, 8'h00, 8'h03, 1'b1, 1'b0},
    '{12'h211, 8'h01, 8'h00, 8'h03, 1'b1, 1'b0}, '{12'h209, 8'h00, 8'h00, 8'h01, 1'b0, 1'b1},
    '{12'h202, 8'h00, 8'h00, 8'h03, 1'b1, 1'b0}, '{12'h202, 8'h00, 8'h00, 8'h02, 1'b0, 1'b1},
    '{12'h203, 8'h00, 8'h00, 8'h03, 1'b1, 1'b0}, '{12'h204, 8'h01, 8'h01, 8'h00, 1'b1, 1'b0},
    '{12'h20C, 8'h03, 8'h03, 8'h00, 1'b1, 1'b0}, '{12'h214, 8'h01, 8'h03, 8'h00, 1'b1, 1'b0},
    '{12'h2E0, 8'h00, 8'h00, 8'hFF, 1'b1, 1'b0}, '{12'h200, 8'h00, 8'h00, 8'h01, 1'b1, 1'b0}};
  localparam logic [4:0]  RA [6] = '{`OFS_CTRL, `OFS_FILTER, `OFS_SIMUL, `OFS_DWELL,
                                     `OFS_PATTERN, `OFS_IRQ_MASK};
  localparam logic [31:0] RV [6] = '{`CTRL_RESET, `FILTER_RESET, `SIMUL_RESET, `DWELL_RESET,
                                     `PATTERN_RESET, 32'h0};
  logic        clk_in       = 1'b0;
  logic        rst_b_in     = 1'b0;
  logic        ce_in        = 1'b1;
  logic [4:0]  address_in   = 5'h00;
  logic        read_in      = 1'b0;
  logic        write_in     = 1'b0;
  logic [31:0] writedata_in = 32'h0;
  logic        lamp_in      = 1'b0;
  logic [7:0]  act          = 8'h00;
  logic [7:0]  nc           = 8'h00;
  logic        btn          = 1'b0;
  logic        share        = 1'b0;
  logic [31:0] readdata_out;
  logic        waitrequest_out;
  logic [7:0]  pin_in;
  logic        pb_drive_out;
  logic        pb_oe_out;
  logic        on_out;
  logic        error_out;
  logic        irq_out;
  logic [31:0] rd;
  int          n_errors     = 0;
  int          tests_run    = 0;
  int          cycles       = 0;
  int          i;
  int          k;

  safety_input_evaluator #(.MS_CYCLES(10), .PB_OUT_CYC(6), .PB_IN_CYC(2), .PINS(8)) u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .address_in(address_in),
    .read_in(read_in), .write_in(write_in), .writedata_in(writedata_in),
    .readdata_out(readdata_out), .waitrequest_out(waitrequest_out), .pin_in(pin_in),
    .lamp_in(lamp_in), .pb_drive_out(pb_drive_out), .pb_oe_out(pb_oe_out),
    .on_out(on_out), .error_out(error_out), .irq_out(irq_out));
  field_contacts_model u_field (
    .act_in(act), .nc_in(nc), .btn_in(btn), .share_in(share), .drive_in(pb_drive_out),
    .oe_in(pb_oe_out), .pin_out(pin_in));

  // ----------------------------------------------------------------
  // clock, hang guard and helpers
  // ----------------------------------------------------------------
  // free-running 100 MHz clock
  always #5 clk_in = ~clk_in;
  // the whole run needs well under this many cycles
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // one bus access, held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    address_in   <= a;
    writedata_in <= d;
    write_in     <= wr;
    read_in      <= !wr;
    @(posedge clk_in);
    while (waitrequest_out !== 1'b0)
      @(posedge clk_in);
    rd = readdata_out;
    write_in <= 1'b0;
    read_in  <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    cyc(8);
    rst_b_in <= 1'b1;
    bus(1, `OFS_FILTER, 32'h2);
    bus(1, `OFS_SIMUL, 32'h5);
    // every contact variant but the push button, from idle to actuated
    for (i = 0; i < 12; i++)
    begin
      bus(1, `OFS_CTRL, {20'h0, ROWS[i].ctrl});
      nc  <= ROWS[i].nc;
      act <= ROWS[i].off_act;
      cyc(100);
      act <= ROWS[i].on_act;
      cyc(200);
      check(on_out, ROWS[i].exp_on, "on level");
      check(error_out, ROWS[i].exp_err, "error level");
      bus(0, `OFS_STATE, 32'h0);
      check(rd[2:0], ROWS[i].exp_on ? ST_ON : ST_ERR, "state field");
      $display("variant row %0d done", i);
    end
    // short pulse is filtered, long press passes; irq mask and clear
    bus(1, `OFS_CTRL, 32'h200);
    nc  <= 8'h00;
    act <= 8'h00;
    cyc(100);
    bus(1, `OFS_IRQ_STAT, 32'hF);
    act <= 8'h01;
    cyc(15);
    act <= 8'h00;
    cyc(30);
    check(on_out, 1'b0, "pulse filtered");
    act <= 8'h01;
    cyc(19);
    check(on_out, 1'b0, "on before filter");
    cyc(41);
    check(on_out, 1'b1, "on after filter");
    bus(0, `OFS_IRQ_STAT, 32'h0);
    check(rd[3:0], 4'h1, "entered on status");
    check(irq_out, 1'b0, "masked irq");
    bus(1, `OFS_IRQ_MASK, 32'h1);
    cyc(2);
    check(irq_out, 1'b1, "unmasked irq");
    bus(1, `OFS_IRQ_STAT, 32'h1);
    cyc(2);
    check(irq_out, 1'b0, "cleared irq");
    bus(1, `OFS_STATE, 32'h0);
    bus(0, `OFS_STATE, 32'h0);
    check(rd[2:0], ST_ON, "state is read only");
    $display("filter test done");
    // dwell: re-press too soon is held off
    bus(1, `OFS_DWELL, 32'h5);
    bus(1, `OFS_CTRL, 32'h600);
    act <= 8'h00;
    cyc(10);
    act <= 8'h01;
    cyc(200);
    check(on_out, 1'b0, "dwell not met");
    act <= 8'h00;
    cyc(80);
    act <= 8'h01;
    cyc(80);
    check(on_out, 1'b1, "dwell met");
    $display("dwell test done");
    // simultaneity failure latches until all contacts open
    bus(1, `OFS_CTRL, 32'h209);
    act <= 8'h00;
    cyc(100);
    bus(1, `OFS_IRQ_STAT, 32'hF);
    bus(1, `OFS_IRQ_MASK, 32'h8);
    act <= 8'h01;
    cyc(150);
    check(error_out, 1'b1, "simultaneity error");
    check(irq_out, 1'b1, "simultaneity irq");
    act <= 8'h03;
    cyc(100);
    check(on_out, 1'b0, "retry refused");
    bus(0, `OFS_IRQ_STAT, 32'h0);
    check(rd[3:2], 2'b11, "error status bits");
    bus(1, `OFS_IRQ_STAT, 32'hC);
    cyc(2);
    check(irq_out, 1'b0, "irq cleared");
    act <= 8'h00;
    cyc(50);
    check(error_out, 1'b0, "error left");
    act <= 8'h03;
    cyc(100);
    check(on_out, 1'b1, "retry accepted");
    $display("simultaneity test done");
    // per-pin patterns: invalid level, then an inverted on pattern
    bus(1, `OFS_CTRL, 32'h200);
    act <= 8'h00;
    bus(1, `OFS_PATTERN, 32'h0101);
    cyc(10);
    check(error_out, 1'b1, "invalid pattern");
    bus(1, `OFS_PATTERN, 32'h00FF);
    cyc(20);
    check(error_out, 1'b0, "pattern valid");
    bus(1, `OFS_PATTERN, 32'h0100);
    cyc(100);
    check(on_out, 1'b1, "low counts as on");
    bus(1, `OFS_PATTERN, 32'h00FF);
    $display("pattern test done");
    // push button: shared pin timing, lamp and filtered press
    share   <= 1'b1;
    lamp_in <= 1'b1;
    bus(1, `OFS_CTRL, 32'h805);
    cyc(20);
    @(negedge clk_in);
    while (pb_oe_out !== 1'b0)
      @(negedge clk_in);
    while (pb_oe_out !== 1'b1)
      @(negedge clk_in);
    check(pb_drive_out, 1'b1, "lamp lit");
    k = 0;
    while (pb_oe_out === 1'b1)
    begin
      k++;
      @(negedge clk_in);
    end
    check(k, 6, "drive phase");
    k = 0;
    while (pb_oe_out === 1'b0)
    begin
      k++;
      @(negedge clk_in);
    end
    check(k, 2, "sense phase");
    @(posedge clk_in);
    lamp_in <= 1'b0;
    cyc(4);
    check(pb_drive_out, 1'b0, "lamp dark");
    btn <= 1'b1;
    cyc(100);
    check(on_out, 1'b1, "button on");
    btn <= 1'b0;
    cyc(30);
    check(on_out, 1'b0, "button off");
    $display("button test done");
    // reset with contacts already closed: defaults, then off-before-on
    share    <= 1'b0;
    act      <= 8'h03;
    rst_b_in <= 1'b0;
    cyc(8);
    rst_b_in <= 1'b1;
    cyc(2);
    check({on_out, error_out, irq_out}, 3'b000, "outputs after reset");
    for (i = 0; i < 6; i++)
    begin
      bus(0, RA[i], 32'h0);
      check(rd, RV[i], "reset value");
    end
    cyc(400);
    check(on_out, 1'b0, "no on at start");
    act <= 8'h00;
    cyc(50);
    act <= 8'h03;
    cyc(300);
    check(on_out, 1'b1, "on after off");
    $display("reset test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
